// File: hw/ssc_map.vh
`ifndef SSC_MAP_VH
`define SSC_MAP_VH
`define SSC_ST_NORMAL 2'h0
`define SSC_ST_STOP 2'h1
`define SSC_ST_SETTLE 2'h2
`define SSC_OSC_SETTLE_SELECT_RESET 3'h4
`define SSC_SETTLE_BASE 12
`define SSC_NF_SLOW_MIN 4'h6
`define SSC_NF_SLOW_MAX 4'hA
`define SSC_PIN3 3
`define SSC_PIN_IDLE 17'h10000
`endif

// File: hw/ssc_stop_ctrl.v
`include "ssc_map.vh"
`default_nettype none
module ssc_stop_ctrl #(
  parameter SETTLE_BASE = `SSC_SETTLE_BASE,
  parameter CNT_W       = 20
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // mode and control bits
  input  wire        save_mode_bit_hi,
  input  wire        save_mode_bit_lo,
  input  wire        stop_request,
  input  wire        nonmaskable_mask_a,
  input  wire        nonmaskable_mask_b,
  input  wire        maskable_irq_mask,
  input  wire [2:0]  osc_settle_select,
  input  wire        nf_filter_on,
  input  wire [3:0]  nf_div_log2,
  // wake sources
  input  wire        nmi_pin,
  input  wire        watchdog_irq,
  input  wire [14:0] ext_irq_pin,
  input  wire [14:0] ext_irq_mask,
  input  wire        periph_irq,
  input  wire        irq_pending,
  input  wire        reset_pin_n,
  input  wire        watchdog_reset,
  input  wire        power_on_clear,
  input  wire        low_voltage_detect,
  // cpu interrupt state
  input  wire        irq_enabled_state,
  input  wire        in_service,
  input  wire [2:0]  in_service_level,
  input  wire [2:0]  req_level,
  // peripheral clock selections
  input  wire        subclock_used,
  input  wire        watch_sub_sel,
  input  wire        interval_slow_sel,
  input  wire        watchdog_slow_sel,
  input  wire [2:0]  serial_clock_input,
  input  wire        async_ext_clock_pin,
  input  wire        adc_running,
  input  wire        adc_invalid_ack,
  // status
  output reg         stop_active,
  output reg         settling,
  output reg         sys_reset_hold,
  // clock gates
  output reg         main_osc_enable,
  output reg         sub_osc_enable,
  output reg         cpu_clk_en,
  output reg         periph_clk_en,
  output reg         pll_en,
  output reg         dma_en,
  output reg         timer_grp_en,
  output reg         intc_clk_en,
  output reg         intc_detect_en,
  output reg         watch_timer_en,
  output reg         interval_timer_en,
  output reg         watchdog_en,
  output reg  [2:0]  clk_serial_en,
  output reg  [3:0]  async_serial_en,
  output reg         key_irq_en,
  output reg         port_hold,
  output reg         ram_retain,
  // wake outcome pulses
  output reg         wake_branch,
  output reg         wake_next_instr,
  output reg         wake_ack,
  output reg         wake_keep_pending,
  // converter
  output reg         adc_pause,
  output reg         adc_restart,
  output reg         adc_result_invalid
);

  // last count of the settle interval, 2^(base+sel) periods
  function [CNT_W-1:0] settle_last;
    input [2:0] sel;
    reg   [CNT_W:0] one;
    begin
      one         = {{CNT_W{1'b0}}, 1'b1} << (SETTLE_BASE + sel);
      settle_last = one[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // pin inputs: three stages, accept once stages two and three agree
  // a one-cycle glitch never reaches pin_f; a level must stand two edges
  // reset pin idles high, so the stages start in the released state
  wire [16:0] pin_raw = {reset_pin_n, nmi_pin, ext_irq_pin};
  reg  [16:0] pin_s1;
  reg  [16:0] pin_s2;
  reg  [16:0] pin_s3;
  reg  [16:0] pin_f;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      pin_s1 <= `SSC_PIN_IDLE;
      pin_s2 <= `SSC_PIN_IDLE;
      pin_s3 <= `SSC_PIN_IDLE;
      pin_f  <= `SSC_PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  // wake decode
  // masks gate the request, not the synchroniser, so unmasking a pin
  // that already stands wakes at once
  reg  [14:0] next_ext_en;
  wire        nf_slow = nf_filter_on && (nf_div_log2 >= `SSC_NF_SLOW_MIN) &&
                        (nf_div_log2 <= `SSC_NF_SLOW_MAX);

  always @* begin
    next_ext_en = ~ext_irq_mask;
    if (nf_slow) begin
      next_ext_en[`SSC_PIN3] = 1'b0;
    end
  end

  wire next_nmi_req  = (pin_f[15] & ~nonmaskable_mask_a) |
                       (watchdog_irq & ~nonmaskable_mask_b);
  // pending request counts as a maskable source, so stop ends at once unless maskable_irq_mask is set
  wire next_mask_req = ~maskable_irq_mask &
                       ((|(pin_f[14:0] & next_ext_en)) | periph_irq | irq_pending);
  wire next_rst_req  = ~pin_f[16] | watchdog_reset | power_on_clear |
                       low_voltage_detect;
  // bit hi is a don't care: both 01 and 11 select stop
  wire next_stop_ok  = save_mode_bit_lo & (save_mode_bit_hi | ~save_mode_bit_hi);

  // settle_sel is latched at wake, so a later change of osc_settle_select
  // cannot stretch or cut a running interval
  reg [1:0]       state;
  reg [CNT_W-1:0] settle_cnt;
  reg [2:0]       settle_sel;
  reg             rst_wake;
  reg             nmi_wake;
  reg             adc_resume;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      state              <= `SSC_ST_NORMAL;
      settle_cnt         <= {CNT_W{1'b0}};
      settle_sel         <= `SSC_OSC_SETTLE_SELECT_RESET;
      rst_wake           <= 1'b0;
      nmi_wake           <= 1'b0;
      adc_resume         <= 1'b0;
      sys_reset_hold     <= 1'b0;
      wake_branch        <= 1'b0;
      wake_next_instr    <= 1'b0;
      wake_ack           <= 1'b0;
      wake_keep_pending  <= 1'b0;
      adc_restart        <= 1'b0;
      adc_result_invalid <= 1'b0;
    end else begin
      wake_branch       <= 1'b0;
      wake_next_instr   <= 1'b0;
      wake_ack          <= 1'b0;
      wake_keep_pending <= 1'b0;
      adc_restart       <= 1'b0;
      // an ack in the same cycle as a new set loses: the set is assigned later
      if (adc_invalid_ack) begin
        adc_result_invalid <= 1'b0;
      end
      case (state)
        `SSC_ST_NORMAL: begin
          settle_cnt <= {CNT_W{1'b0}};
          // a reset source outranks a stop store made in the same cycle
          if (next_rst_req) begin
            state          <= `SSC_ST_SETTLE;
            settle_sel     <= `SSC_OSC_SETTLE_SELECT_RESET;
            rst_wake       <= 1'b1;
            sys_reset_hold <= 1'b1;
          end else if (stop_request && next_stop_ok) begin
            state <= `SSC_ST_STOP;
            if (adc_running) begin
              adc_resume         <= 1'b1;
              adc_result_invalid <= 1'b1;
            end
          end
        end
        `SSC_ST_STOP: begin
          settle_cnt <= {CNT_W{1'b0}};
          // reset first: its sequence replaces any interrupt outcome
          if (next_rst_req) begin
            state          <= `SSC_ST_SETTLE;
            settle_sel     <= `SSC_OSC_SETTLE_SELECT_RESET;
            rst_wake       <= 1'b1;
            sys_reset_hold <= 1'b1;
          end else if (next_nmi_req || next_mask_req) begin
            state      <= `SSC_ST_SETTLE;
            settle_sel <= osc_settle_select;
            rst_wake   <= 1'b0;
            nmi_wake   <= next_nmi_req;
          end
        end
        `SSC_ST_SETTLE: begin
          if (next_rst_req && !rst_wake) begin
            // a reset during an interrupt-wake settle restarts as an ordinary reset
            settle_cnt     <= {CNT_W{1'b0}};
            settle_sel     <= `SSC_OSC_SETTLE_SELECT_RESET;
            rst_wake       <= 1'b1;
            sys_reset_hold <= 1'b1;
          end else if (settle_cnt == settle_last(settle_sel)) begin
            state      <= `SSC_ST_NORMAL;
            settle_cnt <= {CNT_W{1'b0}};
            if (adc_resume) begin
              adc_restart        <= 1'b1;
              adc_result_invalid <= 1'b1;
              adc_resume         <= 1'b0;
            end
            // outcome decode: reset gives no pulse, nmi always branches,
            // interrupts disabled resume in line, a request not above the
            // one in service stays pending
            if (rst_wake) begin
              sys_reset_hold <= 1'b0;
              rst_wake       <= 1'b0;
            end else if (nmi_wake) begin
              wake_branch <= 1'b1;
              wake_ack    <= 1'b1;
            end else if (!irq_enabled_state) begin
              wake_next_instr <= 1'b1;
            end else if (in_service && !(req_level < in_service_level)) begin
              wake_next_instr   <= 1'b1;
              wake_keep_pending <= 1'b1;
            end else begin
              wake_branch <= 1'b1;
              wake_ack    <= 1'b1;
            end
            nmi_wake <= 1'b0;
          end else begin
            settle_cnt <= settle_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        // unused code falls back to normal operation
        default: begin
          state <= `SSC_ST_NORMAL;
        end
      endcase
    end
  end

  // gates follow state; the main clock domain stays off until settle ends
  // gates stay shut through settle too: the oscillator may still be
  // unstable, and opening clocks early would hand that to the cpu
  // limitation: outputs lag state by one cycle, so the first stop cycle
  // still shows the run gates
  wire run  = (state == `SSC_ST_NORMAL);
  wire stop = (state == `SSC_ST_STOP);

  always @(posedge ref_clk) begin
    if (!rstn) begin
      stop_active       <= 1'b0;
      settling          <= 1'b0;
      main_osc_enable   <= 1'b1;
      sub_osc_enable    <= 1'b0;
      cpu_clk_en        <= 1'b1;
      periph_clk_en     <= 1'b1;
      pll_en            <= 1'b1;
      dma_en            <= 1'b1;
      timer_grp_en      <= 1'b1;
      intc_clk_en       <= 1'b1;
      intc_detect_en    <= 1'b1;
      watch_timer_en    <= 1'b1;
      interval_timer_en <= 1'b1;
      watchdog_en       <= 1'b1;
      clk_serial_en     <= 3'h7;
      async_serial_en   <= 4'hF;
      key_irq_en        <= 1'b1;
      port_hold         <= 1'b0;
      ram_retain        <= 1'b1;
      adc_pause         <= 1'b0;
    end else begin
      stop_active       <= stop;
      settling          <= (state == `SSC_ST_SETTLE);
      main_osc_enable   <= !stop;
      sub_osc_enable    <= subclock_used;
      cpu_clk_en        <= run;
      periph_clk_en     <= run;
      pll_en            <= run;
      dma_en            <= run;
      timer_grp_en      <= run;
      intc_clk_en       <= run;
      // the controller keeps its detect path even while its clock is gated
      intc_detect_en    <= 1'b1;
      watch_timer_en    <= run | (subclock_used & watch_sub_sel);
      interval_timer_en <= run | interval_slow_sel;
      watchdog_en       <= run | watchdog_slow_sel;
      clk_serial_en     <= run ? 3'h7 : serial_clock_input;
      async_serial_en   <= run ? 4'hF : {3'h0, async_ext_clock_pin};
      key_irq_en        <= 1'b1;
      port_hold         <= !run;
      ram_retain        <= 1'b1;
      adc_pause         <= !run & adc_resume;
    end
  end

endmodule // ssc_stop_ctrl
`default_nettype wire

// File: dv/ssc_stop_ctrl_asserts.sv
`default_nettype none
module ssc_stop_ctrl_asserts #(parameter int SETTLE_BASE = 2) (
  // watched ports
  input wire logic ref_clk, rstn, stop_request, save_mode_bit_lo, nonmaskable_mask_a,
  input wire logic nonmaskable_mask_b, maskable_irq_mask, reset_pin_n, watchdog_reset,
  input wire logic power_on_clear, low_voltage_detect, stop_active, settling, sys_reset_hold,
  input wire logic main_osc_enable, cpu_clk_en, port_hold, ram_retain, key_irq_en,
  input wire logic intc_detect_en, wake_branch, wake_next_instr, wake_ack, wake_keep_pending,
  input wire logic [2:0] osc_settle_select
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [19:0] run;
  logic        rst_seen;
  wire         quiet = reset_pin_n && !watchdog_reset && !power_on_clear && !low_voltage_detect;
  // reset wakes take the default length, so the length check skips them
  always_ff @(posedge ref_clk) begin
    run      <= settling ? run + 20'h1 : 20'h0;
    rst_seen <= (settling || sys_reset_hold) && (rst_seen || sys_reset_hold);
  end
  property p_gate; stop_active |-> !main_osc_enable && !cpu_clk_en && port_hold; endproperty
  a_gate: assert property (p_gate) else $error("clock open in stop");
  property p_keep; ram_retain && key_irq_en && intc_detect_en; endproperty
  a_keep: assert property (p_keep) else $error("retention lost");
  property p_enter; stop_request && save_mode_bit_lo && !stop_active && !settling
    && !sys_reset_hold && quiet |-> ##2 stop_active; endproperty
  a_enter: assert property (p_enter) else $error("stop not entered");
  property p_refuse; stop_request && !save_mode_bit_lo && !stop_active && !settling
    |-> ##2 !stop_active; endproperty
  a_refuse: assert property (p_refuse) else $error("stop entered in wrong mode");
  property p_len; $fell(settling) && !rst_seen && !sys_reset_hold
    |-> run == (20'h1 << (SETTLE_BASE + osc_settle_select)); endproperty
  a_len: assert property (p_len) else $error("settle length wrong");
  property p_ack; wake_branch |-> wake_ack && !wake_next_instr; endproperty
  a_ack: assert property (p_ack) else $error("branch without ack");
  property p_pend; wake_keep_pending |-> wake_next_instr && !wake_ack && !wake_branch; endproperty
  a_pend: assert property (p_pend) else $error("pending request taken");
  property p_masked; (stop_active && nonmaskable_mask_a && nonmaskable_mask_b
    && maskable_irq_mask && quiet) [*6] |=> stop_active; endproperty
  a_masked: assert property (p_masked) else $error("masked wake");
endmodule // ssc_stop_ctrl_asserts
`default_nettype wire

// File: dv/ssc_cpu_model.sv
`default_nettype none
module ssc_cpu_model (
  // bench command and stop store
  input  wire logic ref_clk,
  input  wire logic go,
  output var  logic stop_request
);
  timeunit 1ns; timeprecision 1ps;
  int nops = 0;
  // five-cycle no-op tail after the store blocks a further store
  always @(posedge ref_clk) begin
    stop_request <= 1'b0;
    if (nops > 0) nops <= nops - 1;
    else if (go) begin
      stop_request <= 1'b1;
      nops         <= 5;
    end
  end
endmodule // ssc_cpu_model
`default_nettype wire

// File: dv/tb_stop_mode_standby_control.sv
`default_nettype none
module tb_stop_mode_standby_control;
  timeunit 1ns; timeprecision 1ps;
  localparam int SB = 2;
  logic ref_clk = 0, rstn = 0, go = 0, stop_request, save_mode_bit_hi = 0, save_mode_bit_lo = 1;
  logic nonmaskable_mask_a = 0, nonmaskable_mask_b = 0, maskable_irq_mask = 0, nmi_pin = 0;
  logic nf_filter_on = 0, watchdog_irq = 0, periph_irq = 0, irq_pending = 0, reset_pin_n = 1;
  logic watchdog_reset = 0, power_on_clear = 0, low_voltage_detect = 0, in_service = 0;
  logic irq_enabled_state = 0, subclock_used = 0, watch_sub_sel = 0, interval_slow_sel = 0;
  logic watchdog_slow_sel = 0, async_ext_clock_pin = 0, adc_running = 0, adc_invalid_ack = 0;
  logic [2:0] osc_settle_select = 3'h1, in_service_level = 0, req_level = 0;
  logic [2:0] serial_clock_input = 0;
  logic [3:0] nf_div_log2 = 0, got, exp;
  logic [14:0] ext_irq_pin = 0, ext_irq_mask = 0;
  logic stop_active, settling, sys_reset_hold, main_osc_enable, sub_osc_enable, cpu_clk_en;
  logic periph_clk_en, pll_en, dma_en, timer_grp_en, intc_clk_en, intc_detect_en, port_hold;
  logic watch_timer_en, interval_timer_en, watchdog_en, key_irq_en, ram_retain, wake_branch;
  logic wake_next_instr, wake_ack, wake_keep_pending, adc_pause, adc_restart, adc_result_invalid;
  logic [2:0] clk_serial_en;
  logic [3:0] async_serial_en;
  int failures = 0, samples_checked = 0, kind, n;
  ssc_stop_ctrl #(.SETTLE_BASE(SB)) dut (.*);
  ssc_cpu_model cpu (.*);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic cyc(int k = 1); repeat (k) @(posedge ref_clk); #1; endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic enter; go = 1; cyc; go = 0; cyc(5); endtask
  function automatic logic [3:0] pulses;
    return {wake_branch, wake_next_instr, wake_ack, wake_keep_pending};
  endfunction
  initial begin #100000; failures++; results; end
  initial begin
    void'($urandom(76688));
    cyc(10); rstn = 1; cyc(4);
    repeat (24) begin
      kind = $urandom_range(4, 0);
      {subclock_used, watch_sub_sel, interval_slow_sel, watchdog_slow_sel, async_ext_clock_pin,
       irq_enabled_state, in_service, adc_running, save_mode_bit_hi, nf_filter_on} = 10'($urandom);
      {serial_clock_input, in_service_level, req_level, nf_div_log2} = 13'($urandom);
      osc_settle_select = 3'($urandom_range(3, 1));
      n = $urandom_range(13, 0);
      n = n > 2 ? n + 1 : n; // pin three has its own scenario
      ext_irq_mask = 15'($urandom) & ~(15'h1 << n);
      irq_pending = (kind == 4);
      enter;
      if (kind < 4) chk({stop_active, main_osc_enable, cpu_clk_en, periph_clk_en, pll_en, dma_en,
        timer_grp_en, intc_clk_en, port_hold, sub_osc_enable, watch_timer_en, interval_timer_en,
        watchdog_en, clk_serial_en, async_serial_en, adc_pause, adc_result_invalid},
        {9'h101, subclock_used,
        subclock_used & watch_sub_sel, interval_slow_sel, watchdog_slow_sel, serial_clock_input,
        3'h0, async_ext_clock_pin, adc_running, adc_running});
      {nmi_pin, watchdog_irq, periph_irq} = 3'(4 >> kind);
      ext_irq_pin[n] = (kind == 3);
      got = 0;
      for (int i = 0; i < 400 && got == 0; i++) begin cyc; got = pulses(); end
      exp = kind < 2 ? 4'hA : !irq_enabled_state ? 4'h4
          : in_service && req_level >= in_service_level ? 4'h5 : 4'hA;
      chk(got, exp);
      chk(adc_restart, adc_running);
      {nmi_pin, watchdog_irq, periph_irq, irq_pending, ext_irq_pin} = 0;
      cyc(3);
      chk({cpu_clk_en, stop_active, adc_result_invalid}, {2'h2, adc_running});
      adc_invalid_ack = 1; cyc; adc_invalid_ack = 0; cyc(4);
    end
    save_mode_bit_lo = 0; enter; chk(stop_active, 1'b0); save_mode_bit_lo = 1;
    {nonmaskable_mask_a, nonmaskable_mask_b, maskable_irq_mask} = 3'h7; enter;
    {nmi_pin, watchdog_irq, periph_irq, irq_pending} = 4'hF; cyc(20);
    chk(stop_active, 1'b1);
    {nmi_pin, watchdog_irq, periph_irq, irq_pending, maskable_irq_mask, ext_irq_mask} = 0;
    nf_filter_on = 1; nf_div_log2 = 4'($urandom_range(10, 6)); ext_irq_pin = 15'h0008; cyc(20);
    chk(stop_active, 1'b1);
    ext_irq_pin = 0;
    // one reset source; the pin must stand two edges to pass its filter
    kind = $urandom_range(3, 0);
    {reset_pin_n, watchdog_reset, power_on_clear, low_voltage_detect} = 4'(8 ^ (1 << kind));
    cyc(kind == 3 ? 2 : 1);
    {reset_pin_n, watchdog_reset, power_on_clear, low_voltage_detect} = 4'h8;
    for (int i = 0; i < 8 && !sys_reset_hold; i++) cyc;
    n = 0; got = 0;
    while (sys_reset_hold === 1'b1 && n < 200) begin n++; got |= pulses(); cyc; end
    chk(n, 1 << (SB + 4));
    got |= pulses();
    cyc;
    chk({got, cpu_clk_en, stop_active}, 6'h02);
    results;
  end
endmodule // tb_stop_mode_standby_control
bind ssc_stop_ctrl ssc_stop_ctrl_asserts #(.SETTLE_BASE(SETTLE_BASE)) chk_u (.*);
`default_nettype wire
